// ===== design/gpio_map.vh
// register map and field constants for the general purpose io port
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH
`define GPIO_DATA_IDX 8'h52
`define GPIO_DIR_IDX 8'h54
`define GPIO_DATA_ADDR 12'h148
`define GPIO_DIR_ADDR 12'h150
`define GPIO_DATA_RST 8'h00
`define GPIO_DIR_RST 8'h00
`define GPIO_DATA_MASK 8'h3f
`define GPIO_P1_INPUT 2'b00
`define GPIO_P1_PUSH 2'b01
`define GPIO_P1_OPEN 2'b10
`define GPIO_P1_RSVD 2'b11
`define GPIO_SRC_BIT 7
`define GPIO_PIN4_BIT 3
`define GPIO_NPINS 6
`endif

// ===== design/gpio_pin.v
// one push-pull general purpose pin cell for pins two to six
`timescale 1ns/1ps
`default_nettype none
module gpio_pin (
  input wire mclk,
  input wire rst_b,
  input wire dir_out,
  input wire data_bit,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output reg pin_sense
);
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pin_sense <= 1'b0;
    end else begin
      pin_oe <= dir_out; // see [RULE3] see [RULE13]
      pin_out <= data_bit; // see [RULE4] see [RULE6]
      pin_sense <= pin_in; // see [RULE5]
    end
  end
endmodule
`default_nettype wire

// ===== design/gpio_port.v
// general purpose io port top with apb register slave
// Overview of operation
// [RULE1] data register at index 52h/53h; bits 0-5 are pins 1-6, 6-7 reserved
// [RULE2] software writes reserved bits zero; readback of them is not guaranteed zero
// [RULE3] each pin is input or output per its direction setting
// [RULE4] written data is latched and presented on the pin
// [RULE5] data read returns sensed pin level in either direction
// [RULE6] push-pull output drives high for one, low for zero
// [RULE7] pin one direction field 10 selects open-drain relay driver
// [RULE8] open-drain one pulls pin low, zero releases it
// [RULE9] open-drain read of pin one returns inverted pin level
// [RULE10] direction register at index 54h/55h; source bit, pin directions, pin one field
// [RULE11] period source bit zero uses polarity detector, one uses pin four
// [RULE12] pin one field: 00 input, 01 push-pull, 10 open drain, 11 reserved
// [RULE13] pins two to six: direction zero input, one push-pull output
// [RULE14] output latches clear to zero at reset
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.vh"
module gpio_port #(
  parameter NPINS = `GPIO_NPINS
) (
  input wire MCLK,
  input wire RST_B,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [NPINS-1:0] PIN_IN,
  output wire [NPINS-1:0] PIN_OUT,
  output wire [NPINS-1:0] PIN_OE,
  input wire POLARITY_IN,
  output reg PERIOD_DET_IN
);
  // bus phases and register selects
  wire setup;
  wire access;
  wire wr_fire;
  wire rd_take;
  wire hit_data;
  wire hit_dir;
  wire hit_any;

  // software visible registers and their next values
  reg [7:0] data_r;
  reg [7:0] data_nxt;
  reg [7:0] dir_r;
  reg [7:0] dir_nxt;

  // next values of the bus answer
  reg pready_nxt;
  reg pslverr_nxt;
  reg [31:0] prdata_nxt;
  reg [7:0] rd_nxt;

  // pin one cell, the only pin with an open drain mode
  reg p1_out_r;
  reg p1_out_nxt;
  reg p1_oe_r;
  reg p1_oe_nxt;
  reg p1_sense_r;
  wire [1:0] p1_mode;
  wire p1_open;

  // period detector feed
  reg period_nxt;

  // sensed levels of all pins
  wire [NPINS-1:0] sense;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && PREADY;
  assign wr_fire = access && PWRITE;
  assign rd_take = setup && !PWRITE;
  assign hit_data = (PADDR == `GPIO_DATA_ADDR);
  assign hit_dir = (PADDR == `GPIO_DIR_ADDR);
  assign hit_any = hit_data || hit_dir;
  assign p1_mode = dir_r[1:0];
  assign p1_open = (p1_mode == `GPIO_P1_OPEN);

  // a write lands at the edge that completes the access, never in setup
  always @* begin
    data_nxt = data_r;
    if (wr_fire && hit_data) begin
      data_nxt = PWDATA[7:0]; // see [RULE1] see [RULE4]
    end
  end

  always @* begin
    dir_nxt = dir_r;
    if (wr_fire && hit_dir) begin
      dir_nxt = PWDATA[7:0]; // see [RULE10]
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      data_r <= `GPIO_DATA_RST; // see [RULE14]
    end else begin
      data_r <= data_nxt;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      dir_r <= `GPIO_DIR_RST; // see [RULE11]
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // read byte: sensed levels in bits 0-5, stored data_r bits 6-7, pin one inverted in open drain; direction reads return dir_r
  always @* begin
    rd_nxt = 8'h00;
    if (hit_data) begin
      rd_nxt = {data_r[7:6], sense[NPINS-1:1], sense[0]}; // see [RULE5] see [RULE2]
      if (p1_open) begin
        rd_nxt[0] = ~sense[0]; // see [RULE9]
      end
    end else if (hit_dir) begin
      rd_nxt = dir_r;
    end
  end

  // zero wait state: the answer always follows the setup cycle by one edge
  always @* begin
    pready_nxt = setup;
    pslverr_nxt = setup && !hit_any;
    prdata_nxt = PRDATA;
    if (rd_take) begin
      prdata_nxt = {24'h000000, rd_nxt};
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= pready_nxt;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= pslverr_nxt;
    end
  end

  // read data stands until the next read setup
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h00000000;
    end else begin
      PRDATA <= prdata_nxt;
    end
  end

  // pin one drive: input, push-pull or open drain relay driver
  always @* begin
    p1_out_nxt = 1'b0;
    p1_oe_nxt = 1'b0;
    case (p1_mode) // see [RULE12] see [RULE3]
      `GPIO_P1_INPUT: begin
        p1_out_nxt = 1'b0;
        p1_oe_nxt = 1'b0;
      end
      `GPIO_P1_PUSH: begin
        p1_out_nxt = data_r[0]; // see [RULE6]
        p1_oe_nxt = 1'b1;
      end
      `GPIO_P1_OPEN: begin
        // only the pull-down is ever enabled, so a one pulls the pin low
        p1_out_nxt = 1'b0; // see [RULE7] see [RULE8]
        p1_oe_nxt = data_r[0];
      end
      default: begin
        // reserved code leaves the pin undriven
        p1_out_nxt = 1'b0;
        p1_oe_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      p1_out_r <= 1'b0;
    end else begin
      p1_out_r <= p1_out_nxt;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      p1_oe_r <= 1'b0;
    end else begin
      p1_oe_r <= p1_oe_nxt;
    end
  end

  // sensed level is registered like the other cells, so all pins read in step
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      p1_sense_r <= 1'b0;
    end else begin
      p1_sense_r <= PIN_IN[0]; // see [RULE5]
    end
  end

  // period detector takes the polarity detector or pin four
  always @* begin
    if (dir_r[`GPIO_SRC_BIT]) begin
      period_nxt = PIN_IN[`GPIO_PIN4_BIT]; // see [RULE11]
    end else begin
      period_nxt = POLARITY_IN;
    end
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PERIOD_DET_IN <= 1'b0;
    end else begin
      PERIOD_DET_IN <= period_nxt;
    end
  end

  assign sense[0] = p1_sense_r;
  assign PIN_OUT[0] = p1_out_r;
  assign PIN_OE[0] = p1_oe_r;

  // pins two to six are plain push-pull cells
  genvar i;
  generate
    for (i = 1; i < NPINS; i = i + 1) begin : g_pin
      gpio_pin u_pin (
        .mclk(MCLK),
        .rst_b(RST_B),
        .dir_out(dir_r[i+1]), // see [RULE13]
        .data_bit(data_r[i]),
        .pin_in(PIN_IN[i]),
        .pin_out(PIN_OUT[i]),
        .pin_oe(PIN_OE[i]),
        .pin_sense(sense[i])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ===== dv/general_purpose_io_port_tb_top.sv
// self-checking bench for the io port
`timescale 1ns/1ps
`default_nettype none
module general_purpose_io_port_tb_top;
  logic MCLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, POLARITY_IN = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0;
  logic [5:0] ext = 0;
  logic [7:0] d, v, lv;
  logic [8:0] e, q[$];
  wire logic [31:0] PRDATA;
  wire logic PREADY, PSLVERR, PERIOD_DET_IN;
  wire logic [5:0] PIN_IN, PIN_OUT, PIN_OE;
  int bad_count = 0, samples_checked = 0;
  always #20 MCLK = ~MCLK;
  gpio_port dut_u (
    .MCLK(MCLK),
    .RST_B(RST_B),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE),
    .POLARITY_IN(POLARITY_IN),
    .PERIOD_DET_IN(PERIOD_DET_IN)
  );
  gpio_pins_model pm_u (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext(ext), .pin_in(PIN_IN));
  task print_verdict;
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task xfer(input logic [11:0] a, input logic w, input logic [7:0] wd, input logic [8:0] ex);
    @(posedge MCLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, 24'h0, wd};
    q.push_back(ex);
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    {PSEL, PENABLE} <= 2'b00;
  endtask
  always @(posedge MCLK) if (PSEL && PENABLE && PREADY === 1'b1) begin
    e = q.pop_front();
    samples_checked++;
    if (PSLVERR !== e[8] || !PWRITE && PRDATA !== {24'h0, e[7:0]}) begin
      bad_count++;
      $display("[FAIL] %0t read or error mismatch", $time);
    end
  end
  initial begin
    void'($urandom(32'h0510));
    repeat (16) @(posedge MCLK);
    RST_B <= 1'b1;
    xfer(12'h150, 0, 0, 9'h000);
    for (int i = 0; i < 12; i++) begin
      d = {6'($urandom), 2'(i)};
      v = {2'b00, 6'($urandom)};
      ext <= 6'($urandom);
      POLARITY_IN <= 1'($urandom);
      xfer(12'h150, 1, d, 9'h000);
      xfer(12'h148, 1, v, 9'h000);
      lv = {2'b00, d[6:2] & v[5:1] | ~d[6:2] & ext[5:1],
        d[1:0] == 2'b01 ? v[0] : d[1:0] == 2'b10 ? v[0] | ~ext[0] : ext[0]};
      // pin drive, pin level and sense flops settle before the read setup
      repeat (2) @(posedge MCLK);
      xfer(12'h148, 0, 0, {1'b0, lv});
      xfer(12'h150, 0, 0, {1'b0, d});
      xfer(12'h14c, i[0], 0, 9'h100);
    end
    print_verdict;
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
endmodule
`default_nettype wire

// ===== dv/gpio_pins_model.sv
// far side of the six pins: outside drivers meet the port's drive
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] ext,
  output logic [5:0] pin_in
);
  // a driven bit follows the port, pin one in open drain only pulls low
  assign pin_in = pin_oe & pin_out | ~pin_oe & ext;
endmodule
`default_nettype wire

// ===== dv/gpio_port_sva.sv
// assertions on the io port answers and pin drive
`timescale 1ns/1ps
`default_nettype none
module gpio_port_sva #(
  parameter NPINS = 6
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic POLARITY_IN,
  input wire logic PERIOD_DET_IN,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic [NPINS-1:0] PIN_IN,
  input wire logic [NPINS-1:0] PIN_OUT,
  input wire logic [NPINS-1:0] PIN_OE
);
  logic [7:0] dq_r;
  logic [7:0] dd_r;
  wire logic hit;
  wire logic wr_done;
  assign hit = PADDR == 12'h148 || PADDR == 12'h150;
  // shadow copies follow writes at the edge that completes the access
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      dq_r <= 8'h00;
      dd_r <= 8'h00;
    end else if (wr_done) begin
      if (PADDR == 12'h148) dq_r <= PWDATA[7:0];
      if (PADDR == 12'h150) dd_r <= PWDATA[7:0];
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("late ready");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("long ready");
  a_err_map: assert property (PREADY |-> PSLVERR == !hit)
    else $error("bad slverr");
  a_rdata_high: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("bad rdata");
  a_dir_oe: assert property (PIN_OE[5:1] == $past(dd_r[6:2]))
    else $error("bad oe");
  a_pin_one_oe: assert property (PIN_OE[0] ==
    $past(dd_r[1:0] == 2'b01 || dd_r[1:0] == 2'b10 && dq_r[0])) else $error("bad pin one");
  a_out_data: assert property ((PIN_OUT & PIN_OE) ==
    $past({dq_r[5:1] & dd_r[6:2], dd_r[1:0] == 2'b01 && dq_r[0]})) else $error("bad out");
  a_period_src: assert property ($past(RST_B) |-> PERIOD_DET_IN ==
    $past(dd_r[7] ? PIN_IN[3] : POLARITY_IN)) else $error("bad period source");
endmodule
bind gpio_port gpio_port_sva #(.NPINS(NPINS)) u_sva (.*);
`default_nettype wire
